// ---- pkg/alu_timing_map.svh ----
// Timing figures and field layouts for the execution timing model
`ifndef ALU_TIMING_MAP_SVH
`define ALU_TIMING_MAP_SVH

`define CLK_W 8
`define CNT_W 3
`define OP_W 6

// Case select encodings
`define CASE_BEST 2'h0
`define CASE_CACHE 2'h1
`define CASE_WORST 2'h2

// Width of the extra address time accepted on the side input
`define EXTRA_W 8

`endif

// ---- pkg/alu_timing_pkg.sv ----
// Types for the execution timing model
`include "alu_timing_map.svh"
package alu_timing_pkg;

	// Operation and operand form
	typedef enum logic [5:0] {
		op_sum_to_data,
		op_sum_to_address_reg,
		op_reg_to_mem,
		op_compare_data,
		op_compare_address,
		op_bounds_compare,
		op_word_multiply,
		op_long_multiply,
		op_word_unsigned_divide,
		op_long_unsigned_divide,
		op_word_signed_divide,
		op_long_signed_divide,
		op_quick_load,
		op_immediate_reg,
		op_immediate_mem,
		op_immediate_compare,
		op_decimal_reg,
		op_decimal_mem,
		op_extended_reg,
		op_extended_mem,
		op_compare_memory,
		op_decimal_packing_reg,
		op_decimal_unpacking_reg,
		op_decimal_pack_mem,
		op_single_reg,
		op_single_mem,
		op_sign_extension,
		op_cond_set_reg,
		op_decimal_negate,
		op_cond_set_mem,
		op_test_and_set_reg,
		op_test_and_set_op_mem
	} alu_op_t;

	// Address time added on top of the table figure
	typedef enum logic [1:0] {
		add_none,
		add_fetch_ea,
		add_fetch_imm,
		add_calc_ea
	} add_kind_t;

	// One timing table entry
	typedef struct packed {
		logic [`CLK_W-1:0] clocks;
		logic [`CNT_W-1:0] reads;
		logic [`CNT_W-1:0] prefetches;
		logic [`CNT_W-1:0] writes;
	} timing_t;

	typedef enum logic {
		st_idle,
		st_count
	} seq_state_t;

endpackage : alu_timing_pkg

// ---- verilog/timing_rom.sv ----
// Registered lookup of the clock and bus-cycle figures per operation
`timescale 1ns/1ps
`include "alu_timing_map.svh"
module timing_rom (
	input wire logic clk, // Processor clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic [5:0] op, // Operation code
	input wire logic [1:0] case_sel, // Best, cache or worst case
	output logic [`CLK_W-1:0] clocks, // Table clock total
	output logic [`CNT_W-1:0] reads, // Operand reads
	output logic [`CNT_W-1:0] prefetches, // Instruction prefetches
	output logic [`CNT_W-1:0] writes, // Operand writes
	output logic [1:0] add_kind // Extra address time to add
);

	logic [`CLK_W+3*`CNT_W+1:0] data_reg;
	logic [`CLK_W+3*`CNT_W+1:0] data_next;

	// Pack one entry: clocks, r, p, w, kind
	function automatic logic [`CLK_W+3*`CNT_W+1:0] ent(
		input logic [7:0] c, input logic [2:0] r, input logic [2:0] p,
		input logic [2:0] w, input logic [1:0] k);
		ent = {c, r, p, w, k};
	endfunction : ent

	// Pick one of three figures by case; worst adds one prefetch
	function automatic logic [`CLK_W+3*`CNT_W+1:0] tri3(
		input logic [1:0] cs, input logic [7:0] b, input logic [7:0] c,
		input logic [7:0] wc, input logic [2:0] r, input logic [2:0] w,
		input logic [1:0] k);
		if (cs == `CASE_BEST) begin
			tri3 = ent(b, r, 3'h0, w, k);
		end else if (cs == `CASE_CACHE) begin
			tri3 = ent(c, r, 3'h0, w, k);
		end else begin
			tri3 = ent(wc, r, 3'h1, w, k); // Worst case holds next prefetch
		end
	endfunction : tri3

	// Table of figures, each total includes its bus cycles
	always_comb begin
		data_next = ent(8'h00, 3'h0, 3'h0, 3'h0, 2'h0);
		case (op)
			6'h00, 6'h01, 6'h03:
				data_next = tri3(case_sel, 8'h00, 8'h02, 8'h03, 3'h0, 3'h0,
					2'h1);
			6'h02:
				data_next = tri3(case_sel, 8'h03, 8'h04, 8'h06, 3'h0, 3'h1,
					2'h1);
			6'h04:
				data_next = tri3(case_sel, 8'h01, 8'h04, 8'h04, 3'h0, 3'h0,
					2'h1);
			6'h05:
				data_next = tri3(case_sel, 8'h10, 8'h12, 8'h12, 3'h1, 3'h0,
					2'h2);
			6'h06:
				data_next = tri3(case_sel, 8'h19, 8'h1b, 8'h1c, 3'h0, 3'h0,
					2'h1);
			6'h07:
				data_next = tri3(case_sel, 8'h29, 8'h2b, 8'h2c, 3'h0, 3'h0,
					2'h2);
			6'h08:
				data_next = tri3(case_sel, 8'h2a, 8'h2c, 8'h2c, 3'h0, 3'h0,
					2'h1);
			6'h09:
				data_next = tri3(case_sel, 8'h4c, 8'h4e, 8'h4f, 3'h0, 3'h0,
					2'h2);
			6'h0a:
				data_next = tri3(case_sel, 8'h36, 8'h38, 8'h39, 3'h0, 3'h0,
					2'h1);
			6'h0b:
				data_next = tri3(case_sel, 8'h58, 8'h5a, 8'h5b, 3'h0, 3'h0,
					2'h2);
			6'h0c, 6'h0d, 6'h0f:
				data_next = tri3(case_sel, 8'h00, 8'h02, 8'h03, 3'h0, 3'h0,
					(op == 6'h0c) ? 2'h0 : 2'h2);
			6'h0e:
				data_next = tri3(case_sel, 8'h03, 8'h04, 8'h06, 3'h0, 3'h1,
					2'h2);
			6'h10:
				data_next = tri3(case_sel, 8'h04, 8'h04, 8'h05, 3'h0, 3'h0,
					2'h0);
			6'h11:
				data_next = tri3(case_sel, 8'h0e, 8'h10, 8'h11, 3'h2, 3'h1,
					2'h0);
			6'h12:
				data_next = tri3(case_sel, 8'h02, 8'h02, 8'h03, 3'h0, 3'h0,
					2'h0);
			6'h13:
				data_next = tri3(case_sel, 8'h0a, 8'h0c, 8'h0d, 3'h2, 3'h1,
					2'h0);
			6'h14:
				data_next = tri3(case_sel, 8'h08, 8'h09, 8'h0a, 3'h2, 3'h0,
					2'h0);
			6'h15:
				data_next = tri3(case_sel, 8'h03, 8'h06, 8'h07, 3'h0, 3'h0,
					2'h0);
			6'h16:
				data_next = tri3(case_sel, 8'h05, 8'h08, 8'h09, 3'h0, 3'h0,
					2'h0);
			6'h17:
				data_next = tri3(case_sel, 8'h0b, 8'h0d, 8'h0d, 3'h1, 3'h1,
					2'h0);
			6'h18:
				data_next = tri3(case_sel, 8'h00, 8'h02, 8'h03, 3'h0, 3'h0,
					2'h0);
			6'h19:
				data_next = tri3(case_sel, 8'h03, 8'h04, 8'h06, 3'h0, 3'h1,
					2'h1);
			6'h1a, 6'h1b, 6'h1e:
				data_next = tri3(case_sel, 8'h01, 8'h04, 8'h04, 3'h0, 3'h0,
					2'h0);
			6'h1c:
				data_next = tri3(case_sel, 8'h06, 8'h06, 8'h06, 3'h0, 3'h0,
					2'h0);
			6'h1d:
				data_next = tri3(case_sel, 8'h06, 8'h06, 8'h06, 3'h0, 3'h1,
					2'h3);
			6'h1f:
				data_next = tri3(case_sel, 8'h0c, 8'h0c, 8'h0d, 3'h1, 3'h1,
					2'h3);
			default:
				data_next = ent(8'h00, 3'h0, 3'h0, 3'h0, 2'h0);
		endcase
	end

	// Registered read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= '0;
		end else begin
			data_reg <= data_next;
		end
	end

	assign {clocks, reads, prefetches, writes, add_kind} = data_reg;

endmodule : timing_rom

// ---- verilog/alu_instruction_cycle_timing.sv ----
// Top of the execution timing model: case choice and cycle sequencing
`timescale 1ns/1ps
`include "alu_timing_map.svh"
module alu_instruction_cycle_timing (
	input wire logic clk, // Processor clock, 125 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic start, // One-cycle request to time an operation
	input wire logic [5:0] op, // Operation and operand form
	input wire logic cache_hit, // Instruction is cache resident
	input wire logic prefetch_pending, // A prefetch is still outstanding
	input wire logic [7:0] fetch_ea_time, // Fetch address time
	input wire logic [7:0] fetch_imm_time, // Fetch immediate address time
	input wire logic [7:0] calc_ea_time, // Calculate address time
	output logic busy, // Operation in progress
	output logic done, // One-cycle pulse at the end
	output logic [9:0] total_clocks, // Total execution time of last op
	output logic [2:0] read_cycles, // Operand reads of last op
	output logic [2:0] prefetch_cycles, // Prefetches of last op
	output logic [2:0] write_cycles // Operand writes of last op
);

	logic rst_s1_reg;
	logic rst_n_reg;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	alu_timing_pkg::seq_state_t state_reg;
	alu_timing_pkg::seq_state_t state_next;
	logic [1:0] case_reg;
	logic [1:0] case_next;
	logic [5:0] op_reg;
	logic [5:0] op_next;
	logic [9:0] remain_reg;
	logic [9:0] remain_next;
	logic lookup_reg;
	logic lookup_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;
	logic [9:0] total_reg;
	logic [9:0] total_next;
	logic [2:0] rd_reg;
	logic [2:0] rd_next;
	logic [2:0] pf_reg;
	logic [2:0] pf_next;
	logic [2:0] wr_reg;
	logic [2:0] wr_next;
	logic [7:0] ea_reg;
	logic [7:0] ea_next;
	logic [7:0] imm_reg;
	logic [7:0] imm_next;
	logic [7:0] calc_reg;
	logic [7:0] calc_next;

	logic [7:0] rom_clocks;
	logic [2:0] rom_reads;
	logic [2:0] rom_pf;
	logic [2:0] rom_wr;
	logic [1:0] rom_kind;
	logic [9:0] sum;

	// Case choice: a miss is worst; a hit with a prefetch still out
	// costs the cache figure, a clean hit the best figure
	function automatic logic [1:0] pick_case(input logic hit,
		input logic pend);
		if (!hit) begin
			pick_case = `CASE_WORST;
		end else if (pend) begin
			pick_case = `CASE_CACHE;
		end else begin
			pick_case = `CASE_BEST;
		end
	endfunction : pick_case

	// Table is fed the next values so its registered answer is ready
	// on the lookup edge; feeding the held copy would give stale figures
	timing_rom u_rom (
		.clk(clk),
		.rst_n(rst_n_reg),
		.op(op_next),
		.case_sel(case_next),
		.clocks(rom_clocks),
		.reads(rom_reads),
		.prefetches(rom_pf),
		.writes(rom_wr),
		.add_kind(rom_kind)
	);

	// Table figure plus the flagged address time
	always_comb begin
		sum = {2'h0, rom_clocks};
		case (rom_kind)
			2'h1: sum = {2'h0, rom_clocks} + {2'h0, ea_reg};
			2'h2: sum = {2'h0, rom_clocks} + {2'h0, imm_reg};
			2'h3: sum = {2'h0, rom_clocks} + {2'h0, calc_reg};
			default: sum = {2'h0, rom_clocks};
		endcase
	end

	// Sequencer: latch, look up, then count the total down
	always_comb begin
		state_next = state_reg;
		case_next = case_reg;
		op_next = op_reg;
		remain_next = remain_reg;
		lookup_next = 1'b0;
		busy_next = busy_reg;
		done_next = 1'b0;
		total_next = total_reg;
		rd_next = rd_reg;
		pf_next = pf_reg;
		wr_next = wr_reg;
		ea_next = ea_reg;
		imm_next = imm_reg;
		calc_next = calc_reg;
		case (state_reg)
			alu_timing_pkg::st_idle: begin
				if (start) begin
					op_next = op;
					case_next = pick_case(cache_hit, prefetch_pending);
					ea_next = fetch_ea_time;
					imm_next = fetch_imm_time;
					calc_next = calc_ea_time;
					lookup_next = 1'b1;
					busy_next = 1'b1;
					state_next = alu_timing_pkg::st_count;
				end
			end
			alu_timing_pkg::st_count: begin
				if (lookup_reg) begin
					// Table data lands one cycle after the latch
					total_next = sum;
					rd_next = rom_reads;
					pf_next = rom_pf;
					wr_next = rom_wr;
					if (sum <= 10'h001) begin
						// Zero- and one-clock forms finish on this edge
						busy_next = 1'b0;
						done_next = 1'b1;
						state_next = alu_timing_pkg::st_idle;
					end else begin
						// The lookup edge already counts as one clock
						remain_next = sum - 10'h001;
					end
				end else if (remain_reg <= 10'h001) begin
					busy_next = 1'b0;
					done_next = 1'b1;
					remain_next = 10'h000;
					state_next = alu_timing_pkg::st_idle;
				end else begin
					remain_next = remain_reg - 10'h001;
				end
			end
			default: state_next = alu_timing_pkg::st_idle;
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= alu_timing_pkg::st_idle;
			case_reg <= `CASE_BEST;
			op_reg <= 6'h00;
			remain_reg <= 10'h000;
			lookup_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			total_reg <= 10'h000;
			rd_reg <= 3'h0;
			pf_reg <= 3'h0;
			wr_reg <= 3'h0;
			ea_reg <= 8'h00;
			imm_reg <= 8'h00;
			calc_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			case_reg <= case_next;
			op_reg <= op_next;
			remain_reg <= remain_next;
			lookup_reg <= lookup_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			total_reg <= total_next;
			rd_reg <= rd_next;
			pf_reg <= pf_next;
			wr_reg <= wr_next;
			ea_reg <= ea_next;
			imm_reg <= imm_next;
			calc_reg <= calc_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign total_clocks = total_reg;
	assign read_cycles = rd_reg;
	assign prefetch_cycles = pf_reg;
	assign write_cycles = wr_reg;

endmodule : alu_instruction_cycle_timing

// ---- dv/alu_timing_properties.sv ----
// Concurrent checks on the timing model ports
`timescale 1ns/1ps
module alu_timing_checker (
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic start, // Request
	input wire logic [5:0] op, // Operation
	input wire logic cache_hit, // Cache resident
	input wire logic prefetch_pending, // Prefetch outstanding
	input wire logic [7:0] fetch_imm_time, // Immediate time
	input wire logic busy, // Busy
	input wire logic done, // End pulse
	input wire logic [9:0] total_clocks, // Total
	input wire logic [2:0] read_cycles, // Reads
	input wire logic [2:0] prefetch_cycles, // Prefetches
	input wire logic [2:0] write_cycles // Writes
);
	logic [9:0] span_reg;
	logic [9:0] span_next;
	logic take;
	// Busy cycles since the last accepted request
	always_comb begin
		take = start && !busy;
		span_next = take ? 10'h000 : span_reg + {9'h000, busy};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			span_reg <= 10'h000;
		else
			span_reg <= span_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_take_sets_busy: assert property (take |=> busy)
		else $error("busy not raised");
	a_done_span: assert property (done |-> span_reg ==
		((total_clocks == 10'h000) ? 10'h001 : total_clocks))
		else $error("done at wrong cycle");
	a_done_idle: assert property (done |-> !busy)
		else $error("busy during done");
	a_done_once: assert property (done |=> !done)
		else $error("done longer than a cycle");
	a_busy_end_done: assert property ($fell(busy) |-> done)
		else $error("busy ended without done");
	a_worst_fetch: assert property (take && !cache_hit
		|-> ##2 prefetch_cycles == 3'h1)
		else $error("worst case prefetch");
	a_hit_no_fetch: assert property (take && cache_hit
		|-> ##2 prefetch_cycles == 3'h0)
		else $error("cached case prefetch");
	a_long_mul: assert property (take && op == 6'h07 && !cache_hit
		|-> ##2 total_clocks == 10'h02c + {2'h0, $past(fetch_imm_time, 2)})
		else $error("long multiply total");
	a_decimal_mem: assert property (take && op == 6'h11 && !cache_hit
		|-> ##2 total_clocks == 10'h011 && read_cycles == 3'h2
		&& write_cycles == 3'h1)
		else $error("decimal memory figures");
	a_quick_best: assert property (take && op == 6'h0c && cache_hit
		&& !prefetch_pending |-> ##2 total_clocks == 10'h000 && done)
		else $error("quick load best case");
	c_worst: cover property (take && !cache_hit);
	c_refused: cover property (start && busy);
	c_chain: cover property (done && start);
endmodule : alu_timing_checker

bind alu_instruction_cycle_timing alu_timing_checker alu_timing_checker_i (
	.clk(clk), .reset_n(reset_n), .start(start), .op(op),
	.cache_hit(cache_hit), .prefetch_pending(prefetch_pending),
	.fetch_imm_time(fetch_imm_time), .busy(busy), .done(done),
	.total_clocks(total_clocks), .read_cycles(read_cycles),
	.prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles));

// ---- dv/alu_instruction_cycle_timing_tb.sv ----
// Self-checking bench for the timing model
`timescale 1ns/1ps
module alu_instruction_cycle_timing_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic [5:0] op = 6'h00;
	logic cache_hit = 1'b0;
	logic prefetch_pending = 1'b0;
	logic [7:0] fetch_ea_time = 8'h05;
	logic [7:0] fetch_imm_time = 8'h07;
	logic [7:0] calc_ea_time = 8'h0b;
	logic busy, done;
	logic [9:0] total_clocks;
	logic [2:0] read_cycles, prefetch_cycles, write_cycles;
	int n_mismatch = 0;
	int n_checks = 0;
	// Best, cache and worst clocks in operation code order
	int best[32] = '{0, 0, 3, 0, 1, 16, 25, 41, 42, 76, 54, 88, 0, 0, 3, 0,
		4, 14, 2, 10, 8, 3, 5, 11, 0, 3, 1, 1, 6, 6, 1, 12};
	int cache[32] = '{2, 2, 4, 2, 4, 18, 27, 43, 44, 78, 56, 90, 2, 2, 4, 2,
		4, 16, 2, 12, 9, 6, 8, 13, 2, 4, 4, 4, 6, 6, 4, 12};
	int worst[32] = '{3, 3, 6, 3, 4, 18, 28, 44, 44, 79, 57, 91, 3, 3, 6, 3,
		5, 17, 3, 13, 10, 7, 9, 13, 3, 6, 4, 4, 6, 6, 4, 13};

	alu_instruction_cycle_timing alu_instruction_cycle_timing_i (
		.clk(clk), .reset_n(reset_n), .start(start), .op(op),
		.cache_hit(cache_hit), .prefetch_pending(prefetch_pending),
		.fetch_ea_time(fetch_ea_time), .fetch_imm_time(fetch_imm_time),
		.calc_ea_time(calc_ea_time), .busy(busy), .done(done),
		.total_clocks(total_clocks), .read_cycles(read_cycles),
		.prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles));

	// 125 MHz clock
	initial begin
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// Address time that each operation adds on top of its table figure
	function automatic logic [9:0] extra(input logic [5:0] o);
		case (o)
			6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h19:
				return {2'h0, fetch_ea_time};
			6'h05, 6'h07, 6'h09, 6'h0b, 6'h0d, 6'h0e, 6'h0f:
				return {2'h0, fetch_imm_time};
			6'h1d, 6'h1f:
				return {2'h0, calc_ea_time};
			default:
				return 10'h000;
		endcase
	endfunction : extra

	// Reads and writes packed as {reads, writes}
	function automatic logic [5:0] rw(input logic [5:0] o);
		case (o)
			6'h05: return 6'h08;
			6'h14: return 6'h10;
			6'h11, 6'h13: return 6'h11;
			6'h17, 6'h1f: return 6'h09;
			6'h02, 6'h0e, 6'h19, 6'h1d: return 6'h01;
			default: return 6'h00;
		endcase
	endfunction : rw

	function automatic logic [9:0] exp_tot(input logic [5:0] o,
		input logic h, input logic p);
		int c;
		c = !h ? worst[o] : (p ? cache[o] : best[o]);
		return 10'(c) + extra(o);
	endfunction : exp_tot

	// Request lasts one cycle; returns at the edge that takes it
	task automatic go(input logic [5:0] o, input logic h, input logic p);
		start <= 1'b1;
		op <= o;
		cache_hit <= h;
		prefetch_pending <= p;
		@(posedge clk);
		start <= 1'b0;
	endtask : go

	// Waits for done, bounded, n0 edges already spent since the take
	task automatic await(input logic [5:0] o, input logic h, input logic p,
		input int n0);
		logic [9:0] t;
		int n;
		t = exp_tot(o, h, p);
		n = n0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 300);
		check(10'(n), (t == 10'h000) ? 10'h001 : t);
		check(total_clocks, t);
		check({9'h000, busy}, 10'h000);
		check({4'h0, read_cycles, write_cycles}, {4'h0, rw(o)});
		check({7'h00, prefetch_cycles}, {9'h000, !h});
	endtask : await

	task automatic t_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
		check(total_clocks, 10'h000);
		check({8'h00, busy, done}, 10'h000);
		// First request lands on the third edge after release
		@(posedge clk);
		go(6'h0c, 1'b1, 1'b0);
		await(6'h0c, 1'b1, 1'b0, 0);
		$display("reset test done");
	endtask : t_reset

	// Every operation in best, cache and worst case
	task automatic t_all();
		for (int o = 0; o < 32; o++) begin
			for (int k = 0; k < 3; k++) begin
				@(posedge clk);
				go(6'(o), k != 2, k == 1);
				await(6'(o), k != 2, k == 1, 0);
			end
		end
		$display("table test done");
	endtask : t_all

	// A request while busy must not disturb the running one
	task automatic t_refused();
		@(posedge clk);
		go(6'h0b, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		go(6'h00, 1'b1, 1'b0);
		await(6'h0b, 1'b0, 1'b0, 6);
		$display("refused test done");
	endtask : t_refused

	// Next request given in the done cycle of the previous one
	task automatic t_chain();
		@(posedge clk);
		go(6'h04, 1'b1, 1'b0);
		repeat (6) @(posedge clk);
		go(6'h1f, 1'b0, 1'b0);
		await(6'h1f, 1'b0, 1'b0, 0);
		$display("chain test done");
	endtask : t_chain

	task automatic t_midreset();
		@(posedge clk);
		go(6'h09, 1'b0, 1'b0);
		repeat (10) @(posedge clk);
		reset_n <= 1'b0;
		#1;
		check({8'h00, busy, done}, 10'h000);
		t_reset();
		$display("mid reset test done");
	endtask : t_midreset

	initial begin
		t_reset();
		t_all();
		t_refused();
		t_chain();
		t_midreset();
		results();
	end

	// Whole run needs about 2150 cycles; allow over eleven times that
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
endmodule : alu_instruction_cycle_timing_tb
